// >>> tft_bias_sequencer.sv
`timescale 1ns/1ns
`include "tft_bias_params.svh"
// Functional notes
// - Start on enable rising, or enable high when supply leaves lockout.
// - Enable boost first, then negative rail, then positive rail.
// - Each stage soft-starts and settles two full ramp periods before the next.
// - Ramp period is a parameter, 6 ms reference, also soft-start period.
// - Negative and boost soft-start references follow the timing ramp.
// - All three feedback comparators evaluated after a parameterised period count.
// - All above 80% at evaluation: hold ramp at ground, drive ready low.
// - Any below 80% at evaluation: ready released, fault timer starts at once.
// - Any output dropping below 80% starts fault timer and releases ready.
// - Fault still present at one ramp period end disables all outputs.
// - After fault shutdown stay off until enable cycled or power cycled.
// - Re-enable after shutdown reruns full sequence from the boost stage.
// - Fault clearing before timer expiry restores ready and normal running.
// - Enable low disables all outputs on the third clock edge after it.
// - Ready released about 15 us after a feedback drops below threshold.
// - Ready stays high impedance during startup.
module tft_bias_sequencer
    import tft_bias_pkg::*;
#(
    parameter int unsigned RAMP_CYCLES  = `RAMP_CYCLES,
    parameter period_t     EVAL_PERIODS = `EVAL_PERIODS
) (
    input  wire logic  CLOCK,
    input  wire logic  RESET_N,
    input  wire logic  ENABLE,
    input  wire logic  UVLO_LOCKOUT,
    input  wire logic  BOOST_FEEDBACK_INPUT,
    input  wire logic  NEGATIVE_FEEDBACK_INPUT,
    input  wire logic  POSITIVE_FEEDBACK_INPUT,
    output logic       BOOST_ENABLE,
    output logic       NEGATIVE_RAIL_OUTPUT_EN,
    output logic       POSITIVE_RAIL_OUTPUT_EN,
    output ramp_t      TIMING_CAPACITOR_RAMP,
    output logic       READY_OUT,
    output logic       READY_OE_N
);
    localparam logic [`FILT_W-1:0] FILT_LAST = (`FILT_W)'(`FB_RELEASE_CYCLES - 1);

    // Two-stage synchronisers for the lockout, enable and feedback inputs
    wire  [4:0] raw_in = {UVLO_LOCKOUT, ENABLE, POSITIVE_FEEDBACK_INPUT,
                          NEGATIVE_FEEDBACK_INPUT, BOOST_FEEDBACK_INPUT};
    logic [4:0] sync1_ff;
    logic [4:0] sync2_ff;

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            always_ff @(posedge CLOCK) begin
                if (!RESET_N) begin
                    sync1_ff[gi] <= 1'b0;
                    sync2_ff[gi] <= 1'b0;
                end else begin
                    sync1_ff[gi] <= raw_in[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                end
            end
        end
    endgenerate

    wire uvlo_s = sync2_ff[4];
    wire en_s   = sync2_ff[3];
    wire all_ok = &sync2_ff[2:0];
    wire go     = en_s && !uvlo_s;

    seq_state_t            state_ff;
    seq_state_t            nxt_state;
    period_t               period_ff;
    logic [`FILT_W-1:0]    filt_ff;
    logic                  go_prev_ff;
    logic                  boost_en_ff;
    logic                  neg_en_ff;
    logic                  pos_en_ff;
    logic                  ready_oe_n_ff;
    logic                  ready_out_ff;

    ramp_if rif ();

    ramp_timer #(
        .TERM_CYCLES (RAMP_CYCLES)
    ) u_ramp (
        .clk   (CLOCK),
        .rst_n (RESET_N),
        .rif   (rif)
    );

    // Decodes
    wire go_rise    = go && !go_prev_ff;
    wire period_end = rif.period_end;
    wire neg_due    = period_end && (period_ff == `NEG_START_PERIOD - 4'h1);
    wire pos_due    = period_end && (period_ff == `POS_START_PERIOD - 4'h1);
    wire eval_now   = period_end && (period_ff == EVAL_PERIODS - 4'h1);
    wire fb_trip    = (filt_ff == FILT_LAST) && !all_ok;
    wire in_seq     = (state_ff == S_BOOST) || (state_ff == S_NEG) || (state_ff == S_POS);

    // Ramp runs during sequencing and fault timing, held at ground otherwise
    assign rif.run     = in_seq || (state_ff == S_FAULT);
    assign rif.restart = (state_ff == S_POS) && (nxt_state == S_FAULT);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            S_OFF: begin
                if (go_rise) begin
                    nxt_state = S_BOOST;
                end
            end
            S_BOOST: begin
                if (neg_due) begin
                    nxt_state = S_NEG;
                end
            end
            S_NEG: begin
                if (pos_due) begin
                    nxt_state = S_POS;
                end
            end
            S_POS: begin
                if (eval_now) begin
                    nxt_state = all_ok ? S_RUN : S_FAULT;
                end
            end
            S_RUN: begin
                if (fb_trip) begin
                    nxt_state = S_FAULT;
                end
            end
            S_FAULT: begin
                if (period_end && !all_ok) begin
                    nxt_state = S_SHUT;
                end else if (all_ok) begin
                    nxt_state = S_RUN;
                end
            end
            S_SHUT: begin
                nxt_state = S_SHUT;
            end
        endcase
        if (!go) begin
            nxt_state = S_OFF;
        end
    end

    wire nxt_boost = (nxt_state != S_OFF) && (nxt_state != S_SHUT);
    wire nxt_neg   = nxt_boost && (nxt_state != S_BOOST);
    wire nxt_pos   = nxt_neg && (nxt_state != S_NEG);

    // Lockout clears the sequencer without waiting for a clock
    always_ff @(posedge CLOCK or posedge UVLO_LOCKOUT) begin
        if (UVLO_LOCKOUT) begin
            state_ff      <= S_OFF;
            go_prev_ff    <= 1'b0;
            boost_en_ff   <= 1'b0;
            neg_en_ff     <= 1'b0;
            pos_en_ff     <= 1'b0;
            ready_oe_n_ff <= 1'b1;
        end else if (!RESET_N) begin
            state_ff      <= S_OFF;
            go_prev_ff    <= 1'b0;
            boost_en_ff   <= 1'b0;
            neg_en_ff     <= 1'b0;
            pos_en_ff     <= 1'b0;
            ready_oe_n_ff <= 1'b1;
        end else begin
            state_ff      <= nxt_state;
            go_prev_ff    <= go;
            boost_en_ff   <= nxt_boost;
            neg_en_ff     <= nxt_neg;
            pos_en_ff     <= nxt_pos;
            ready_oe_n_ff <= (nxt_state != S_RUN);
        end
    end

    // Periods elapsed since enable
    always_ff @(posedge CLOCK) begin
        if (!RESET_N || !in_seq) begin
            period_ff <= `PER_RST;
        end else if (period_end) begin
            period_ff <= period_ff + 4'h1;
        end
    end

    // Undervoltage filter before ready is released
    always_ff @(posedge CLOCK) begin
        if (!RESET_N || state_ff != S_RUN || all_ok) begin
            filt_ff <= `FILT_RST;
        end else if (filt_ff != FILT_LAST) begin
            filt_ff <= filt_ff + (`FILT_W)'(1);
        end
    end

    // Ready pin only ever pulls low
    always_ff @(posedge CLOCK) begin
        ready_out_ff <= 1'b0;
    end

    // Cycles spent in fault timing, only read by the checks below
    ramp_t fault_cyc_ff;
    always_ff @(posedge CLOCK) begin
        if (!RESET_N || state_ff != S_FAULT) begin
            fault_cyc_ff <= `RAMP_RST;
        end else begin
            fault_cyc_ff <= fault_cyc_ff + ramp_t'(1);
        end
    end

    assign BOOST_ENABLE            = boost_en_ff;
    assign NEGATIVE_RAIL_OUTPUT_EN = neg_en_ff;
    assign POSITIVE_RAIL_OUTPUT_EN = pos_en_ff;
    assign TIMING_CAPACITOR_RAMP   = rif.level;
    assign READY_OUT               = ready_out_ff;
    assign READY_OE_N              = ready_oe_n_ff;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N || UVLO_LOCKOUT);

    start_seq_a: assert property (
        (state_ff == S_OFF && go_rise) |=> (state_ff == S_BOOST && boost_en_ff && !neg_en_ff))
        else $error("sequence did not start on enable");
    order_neg_a: assert property (neg_en_ff |-> boost_en_ff)
        else $error("negative rail on without boost");
    order_pos_a: assert property (pos_en_ff |-> neg_en_ff)
        else $error("positive rail on without negative rail");
    stage_step_a: assert property (
        (state_ff == S_BOOST && go && neg_due) |=> (neg_en_ff && !pos_en_ff) ##1 neg_en_ff)
        else $error("negative stage not started after two periods");
    eval_pass_a: assert property (
        (state_ff == S_POS && go && eval_now && all_ok)
        |=> (!ready_oe_n_ff && state_ff == S_RUN) ##2 (TIMING_CAPACITOR_RAMP == `RAMP_RST))
        else $error("ready not asserted or ramp not held");
    eval_fail_a: assert property (
        (state_ff == S_POS && go && eval_now && !all_ok)
        |=> (ready_oe_n_ff && state_ff == S_FAULT && TIMING_CAPACITOR_RAMP == `RAMP_RST)
        ##1 (TIMING_CAPACITOR_RAMP == ramp_t'(1)))
        else $error("fault timer not started after failed evaluation");
    trip_rel_a: assert property (
        (state_ff == S_RUN && go && fb_trip) |=> (ready_oe_n_ff && state_ff == S_FAULT))
        else $error("undervoltage did not release ready");
    fault_shut_a: assert property (
        (state_ff == S_FAULT && go && period_end && !all_ok)
        |=> (state_ff == S_SHUT && !boost_en_ff && !neg_en_ff && !pos_en_ff))
        else $error("persistent fault did not shut down");
    shut_hold_a: assert property (
        (state_ff == S_SHUT && go) |=> (state_ff == S_SHUT && !boost_en_ff))
        else $error("restart without enable cycle");
    recover_a: assert property (
        (state_ff == S_FAULT && go && all_ok && !period_end) |=> !ready_oe_n_ff)
        else $error("ready not restored after fault cleared");
    enable_off_a: assert property (
        !go |=> (!boost_en_ff && !neg_en_ff && !pos_en_ff && state_ff == S_OFF))
        else $error("outputs not off with enable low");
    filter_delay_a: assert property (
        (state_ff == S_RUN && go && !all_ok && filt_ff == `FILT_RST)
        |=> !ready_oe_n_ff [*8])
        else $error("ready released before the filter time");
    startup_hiz_a: assert property (in_seq |-> ready_oe_n_ff)
        else $error("ready driven during startup");
    boost_hold_a: assert property (
        (state_ff == S_BOOST) |-> (period_ff < `NEG_START_PERIOD && !neg_en_ff && !pos_en_ff))
        else $error("negative rail started inside the boost periods");
    neg_hold_a: assert property (
        (state_ff == S_NEG)
        |-> (period_ff >= `NEG_START_PERIOD && period_ff < `POS_START_PERIOD && !pos_en_ff))
        else $error("negative stage outside its periods");
    pos_hold_a: assert property (
        (state_ff == S_POS) |-> (period_ff >= `POS_START_PERIOD && period_ff < EVAL_PERIODS))
        else $error("positive stage outside its periods");
    run_full_a: assert property (
        (state_ff == S_RUN) |-> (boost_en_ff && neg_en_ff && pos_en_ff && !ready_oe_n_ff))
        else $error("running without all outputs and ready");
    ramp_hold_a: assert property (
        (state_ff == S_RUN) |=> (TIMING_CAPACITOR_RAMP == `RAMP_RST))
        else $error("ramp not held at ground while running");
    fault_keep_a: assert property (
        (state_ff == S_FAULT) |-> (ready_oe_n_ff && boost_en_ff && neg_en_ff && pos_en_ff))
        else $error("fault timing changed outputs or drove ready");
    fault_len_a: assert property (
        (state_ff == S_FAULT && period_end) |-> (fault_cyc_ff == ramp_t'(RAMP_CYCLES)))
        else $error("fault timer not one ramp period long");
    fault_span_a: assert property (
        (state_ff == S_FAULT) |-> (fault_cyc_ff <= ramp_t'(RAMP_CYCLES)))
        else $error("fault timing overran one ramp period");
    off_quiet_a: assert property (
        (state_ff == S_OFF || state_ff == S_SHUT)
        |-> (!boost_en_ff && !neg_en_ff && !pos_en_ff && ready_oe_n_ff))
        else $error("outputs or ready active while off");
    seq_fresh_a: assert property (
        (state_ff == S_OFF && go_rise)
        |=> (period_ff == `PER_RST && TIMING_CAPACITOR_RAMP == `RAMP_RST))
        else $error("sequence did not restart from the first period");
    ramp_idle_a: assert property (
        (state_ff == S_OFF || state_ff == S_SHUT) |=> (TIMING_CAPACITOR_RAMP == `RAMP_RST))
        else $error("ramp moving while outputs are off");
    pulse_once_a: assert property (period_end |=> !period_end)
        else $error("period end pulse longer than one cycle");

    run_reach_c: cover property (state_ff == S_POS ##1 state_ff == S_RUN);
    recover_c:   cover property (state_ff == S_FAULT ##1 state_ff == S_RUN);
    shutdown_c:  cover property (state_ff == S_FAULT ##1 state_ff == S_SHUT);
    restart_c:   cover property (state_ff == S_SHUT ##[1:20] state_ff == S_BOOST);
    eval_fail_c: cover property (state_ff == S_POS ##1 state_ff == S_FAULT);
endmodule

// >>> tft_bias_params.svh
`ifndef TFT_BIAS_PARAMS_SVH
`define TFT_BIAS_PARAMS_SVH

// Clock and ramp timing
`define CLK_PERIOD_NS      10
`define RAMP_PERIOD_MS     6
`define RAMP_CYCLES        ((`RAMP_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)
`define FB_RELEASE_US      15
`define FB_RELEASE_CYCLES  ((`FB_RELEASE_US * 1000) / `CLK_PERIOD_NS)

// Widths
`define RAMP_W             20
`define PER_W              4
`define FILT_W             11

// Sequence points, in ramp periods counted from enable
`define NEG_START_PERIOD   4'h2
`define POS_START_PERIOD   4'h4
`define EVAL_PERIODS       4'h9

// Reset values
`define RAMP_RST           20'h00000
`define PER_RST            4'h0
`define FILT_RST           11'h000

`endif

// >>> tft_bias_pkg.sv
package tft_bias_pkg;
    typedef enum logic [6:0] {
        S_OFF   = 7'h01,
        S_BOOST = 7'h02,
        S_NEG   = 7'h04,
        S_POS   = 7'h08,
        S_RUN   = 7'h10,
        S_FAULT = 7'h20,
        S_SHUT  = 7'h40
    } seq_state_t;

    typedef logic [19:0] ramp_t;
    typedef logic [3:0]  period_t;
endpackage

// >>> ramp_if.sv
`timescale 1ns/1ns
interface ramp_if;
    import tft_bias_pkg::*;
    logic  run;
    logic  restart;
    logic  period_end;
    ramp_t level;

    modport ctrl  (output run, output restart, input period_end, input level);
    modport timer (input run, input restart, output period_end, output level);
endinterface

// >>> ramp_timer.sv
`timescale 1ns/1ns
`include "tft_bias_params.svh"
module ramp_timer
    import tft_bias_pkg::*;
#(
    parameter int unsigned TERM_CYCLES = `RAMP_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    ramp_if.timer    rif
);
    localparam ramp_t TERM_LAST = ramp_t'(TERM_CYCLES - 1);

    ramp_t cnt_ff;
    logic  end_ff;
    wire   at_term = (cnt_ff == TERM_LAST);
    wire   hold    = !rif.run || rif.restart;

    // Ramp sits at ground while held, wraps at the terminal count
    always_ff @(posedge clk) begin
        if (!rst_n || hold) begin
            cnt_ff <= `RAMP_RST;
        end else if (at_term) begin
            cnt_ff <= `RAMP_RST;
        end else begin
            cnt_ff <= cnt_ff + ramp_t'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            end_ff <= 1'b0;
        end else begin
            end_ff <= !hold && at_term;
        end
    end

    assign rif.level      = cnt_ff;
    assign rif.period_end = end_ff;

    property ramp_wrap_p;
        @(posedge clk) disable iff (!rst_n)
        (rif.run && !rif.restart && at_term) |=> (end_ff && cnt_ff == `RAMP_RST);
    endproperty
    ramp_wrap_a: assert property (ramp_wrap_p)
        else $error("ramp did not wrap with a period pulse");
endmodule

// >>> sys_ctl_model.sv
`timescale 1ns/1ns
module sys_ctl_model (
    input  wire logic clock,
    input  wire logic ready_out,
    input  wire logic ready_oe_n,
    output logic      enable,
    output logic      lockout,
    output wire logic ready_n
);
    // External pull-up: a released ready pin reads high
    assign ready_n = ready_oe_n ? 1'b1 : ready_out;
    initial begin
        enable  = 1'b0;
        lockout = 1'b0;
    end
    task automatic set_enable(input logic v);
        @(negedge clock);
        enable = v;
    endtask
    task automatic set_lockout(input logic v);
        @(negedge clock);
        lockout = v;
    endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import tft_bias_pkg::*;
    localparam int RC = 20;
    logic       clock;
    logic       reset_n;
    logic [2:0] fb;
    logic       en;
    logic       uvlo;
    logic       b_en;
    logic       n_en;
    logic       p_en;
    ramp_t      ramp;
    logic       rdy_out;
    logic       rdy_oe_n;
    wire logic  rdy_n;
    int         error_cnt = 0;
    int         num_checks = 0;
    int         cyc = 0;

    tft_bias_sequencer #(.RAMP_CYCLES(RC)) i_dut (
        .CLOCK(clock), .RESET_N(reset_n), .ENABLE(en), .UVLO_LOCKOUT(uvlo),
        .BOOST_FEEDBACK_INPUT(fb[0]), .NEGATIVE_FEEDBACK_INPUT(fb[1]),
        .POSITIVE_FEEDBACK_INPUT(fb[2]), .BOOST_ENABLE(b_en),
        .NEGATIVE_RAIL_OUTPUT_EN(n_en), .POSITIVE_RAIL_OUTPUT_EN(p_en),
        .TIMING_CAPACITOR_RAMP(ramp), .READY_OUT(rdy_out), .READY_OE_N(rdy_oe_n));
    sys_ctl_model i_ctl (.clock(clock), .ready_out(rdy_out), .ready_oe_n(rdy_oe_n),
        .enable(en), .lockout(uvlo), .ready_n(rdy_n));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("[ERR] timeout expected done seen cycle %0d", cyc);
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        num_checks++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: return b_en;
            1: return n_en;
            2: return p_en;
            default: return rdy_oe_n;
        endcase
    endfunction
    task automatic wait_lvl(input int k, input logic v, input int lim, output int n);
        n = 0;
        while (pick(k) !== v && n < lim) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic chk_off(input string what);
        chk({what, " outputs"}, 20'h00000, {17'h00000, b_en, n_en, p_en});
        chk({what, " ready oe"}, 20'h00001, {19'h00000, rdy_oe_n});
    endtask

    task automatic set_fb(input logic [2:0] v);
        fb = v;
    endtask

    // Full power-on from enable low with all feedback good
    task automatic t_start();
        int n;
        i_ctl.set_enable(1'b1);
        wait_lvl(0, 1'b1, 10, n);
        chk_rng("boost delay", 2, 4, n);
        chk("later stages at boost", 20'h00000, {18'h00000, n_en, p_en});
        wait_lvl(1, 1'b1, 3 * RC, n);
        chk_rng("neg delay", 2 * RC - 2, 2 * RC + 3, n);
        chk("pos at neg", 20'h00000, {19'h00000, p_en});
        chk("ramp moving", 20'h00001, {19'h00000, ramp != 20'h00000});
        wait_lvl(2, 1'b1, 3 * RC, n);
        chk_rng("pos delay", 2 * RC - 2, 2 * RC + 3, n);
        wait_lvl(3, 1'b0, 6 * RC, n);
        chk_rng("ready delay", 5 * RC - 3, 5 * RC + 3, n);
        repeat (2) @(negedge clock);
        chk("ramp held", 20'h00000, ramp);
        chk("ready wire", 20'h00000, {19'h00000, rdy_n});
        $display("test start done");
    endtask
    task automatic t_off();
        i_ctl.set_enable(1'b0);
        repeat (4) @(negedge clock);
        chk_off("disable");
        $display("test off done");
    endtask
    task automatic t_eval_fail();
        int n;
        set_fb(3'h3);
        i_ctl.set_enable(1'b1);
        wait_lvl(2, 1'b1, 10 * RC, n);
        repeat (5 * RC + 4) @(negedge clock);
        chk("eval ready oe", 20'h00001, {19'h00000, rdy_oe_n});
        chk("fault ramp", 20'h00001, {19'h00000, ramp != 20'h00000});
        wait_lvl(0, 1'b0, 2 * RC, n);
        chk_rng("fault expiry", 1, RC, n);
        chk_off("shutdown");
        set_fb(3'h7);
        repeat (3 * RC) @(negedge clock);
        chk_off("stay off");
        i_ctl.set_enable(1'b0);
        repeat (4) @(negedge clock);
        t_start();
        $display("test eval fail done");
    endtask
    task automatic t_run_clear();
        int n;
        set_fb(3'h6);
        repeat (1490) @(negedge clock);
        chk("filtered ready", 20'h00000, {19'h00000, rdy_oe_n});
        wait_lvl(3, 1'b1, 30, n);
        chk_rng("release delay", 1495, 1515, 1490 + n);
        repeat (3) @(negedge clock);
        chk("fault ramp run", 20'h00001, {19'h00000, ramp != 20'h00000});
        set_fb(3'h7);
        wait_lvl(3, 1'b0, 6, n);
        chk_rng("ready back", 1, 5, n);
        chk("outputs kept", 20'h00007, {17'h00000, b_en, n_en, p_en});
        $display("test run clear done");
    endtask
    task automatic t_run_hold();
        int n;
        set_fb(3'h5);
        wait_lvl(3, 1'b1, 1600, n);
        wait_lvl(0, 1'b0, RC + 5, n);
        chk_rng("run expiry", 1, RC + 3, n);
        chk_off("run shutdown");
        set_fb(3'h7);
        t_off();
        $display("test run hold done");
    endtask
    task automatic t_uvlo();
        int n;
        t_start();
        i_ctl.set_lockout(1'b1);
        @(negedge clock);
        chk_off("lockout");
        i_ctl.set_lockout(1'b0);
        wait_lvl(0, 1'b1, 10, n);
        chk_rng("lockout exit", 2, 4, n);
        t_off();
        $display("test lockout done");
    endtask

    initial begin
        reset_n = 1'b0;
        set_fb(3'h7);
        repeat (6) @(negedge clock);
        reset_n = 1'b1;
        chk_off("reset");
        t_start();
        t_off();
        t_eval_fail();
        t_run_clear();
        t_run_hold();
        t_uvlo();
        final_report();
    end
endmodule
